// ### sim/acf_phy_model.sv
// Physical-side partner: takes tx beats and loops them back onto the rx stream
`timescale 1ns/10ps
`default_nettype none
module acf_phy_model
  import acf_pkg::*;
(
  input  wire logic      mclk,
  input  wire logic      reset,
  input  wire logic      slow,
  input  wire logic      hold,
  input  wire logic      corrupt,
  input  wire acf_beat_t txOut,
  output logic           txOutReady,
  output acf_beat_t      rxIn
);
  logic [5:0] idx;
  logic       tick;
  // Slow mode refuses every other cycle; hold parks the next cell at the slot
  assign txOutReady = !hold && (!slow || tick);
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      idx  <= 6'h00;
      tick <= 1'b0;
      rxIn <= '0;
    end else begin
      tick <= !tick;
      if (txOut.valid && txOutReady) begin
        rxIn <= '{1'b1, txOut.first, txOut.last, txOut.data ^ ((corrupt && idx == 6'h04) ? 8'hFF : 8'h00)};
        idx  <= (idx == 6'h34) ? 6'h00 : idx + 6'h01;
      end else begin
        // Idle line inverts its data every cycle, so it toggles between the last byte and its complement
        rxIn <= '{1'b0, 1'b0, 1'b0, ~rxIn.data};
      end
    end
  end
endmodule // acf_phy_model
`default_nettype wire

// ### sim/tb.sv
// Testbench: cells of both formats looped through the physical-side model
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module tb
  import acf_pkg::*;
;
  logic      mclk = 1'b0, reset = 1'b1, cosetOn = 1'b0, txPayloadValid = 1'b0;
  logic      slow = 1'b0, hold = 1'b1, corrupt = 1'b0;
  logic      txPayloadReady, txOutReady, rxInReady, rxHdrValid, rxHdrError;
  logic [7:0] txPayload = 8'h00;
  acf_hdr_t  txHdr, rxHdr;
  acf_beat_t txOut, rxIn, rxPayload;
  int        errors = 0, n_tests = 0, cyc = 0;
  localparam acf_hdr_t H1 = '{1'b0, 12'h0A5, 4'h9, 16'h1234, 3'h5, 1'b1};
  localparam acf_hdr_t H2 = '{1'b1, 12'hC3E, 4'h6, 16'hFEDC, 3'h2, 1'b0};
  localparam acf_hdr_t H3 = '{1'b0, 12'h001, 4'h0, 16'h0001, 3'h0, 1'b0};

  acf_cell_formatter u_dut (.mclk(mclk), .reset(reset), .cosetOn(cosetOn), .txHdr(txHdr), .txPayload(txPayload),
    .txPayloadValid(txPayloadValid), .txPayloadReady(txPayloadReady), .txOut(txOut), .txOutReady(txOutReady),
    .rxIn(rxIn), .rxInReady(rxInReady), .rxHdr(rxHdr), .rxHdrValid(rxHdrValid), .rxHdrError(rxHdrError),
    .rxPayload(rxPayload));
  acf_phy_model u_phy (.mclk(mclk), .reset(reset), .slow(slow), .hold(hold), .corrupt(corrupt),
    .txOut(txOut), .txOutReady(txOutReady), .rxIn(rxIn));

  always #5 mclk = ~mclk;

  task automatic print_verdict();
    $display("comparisons=%0d mismatches=%0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Ceiling is several times the four cells, slow one included
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 2000) begin
      errors++;
      print_verdict();
    end
  end

  function automatic logic [39:0] hdr_bytes(acf_hdr_t h, logic cs);
    logic [31:0] w;
    logic [7:0]  c;
    w = {h.nni ? h.vpi[11:8] : h.gfc, h.vpi[7:0], h.vci, h.ptype, h.lossPri};
    c = 8'h00;
    for (int i = 31; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h07 : 8'h00);
    return {w, c ^ (cs ? 8'h55 : 8'h00)};
  endfunction

  // One cell out and back; the next header and coset go in once this header is judged
  task automatic run_cell(string name, acf_hdr_t h, logic cs, logic bad, logic sl, logic [7:0] sd,
                          acf_hdr_t nh, logic ncs);
    logic [39:0] e;
    int          nt;
    int          nr;
    int          hv;
    e = hdr_bytes(h, cs);
    nt = 0;
    nr = 0;
    hv = 0;
    @(posedge mclk);
    slow <= sl;
    corrupt <= bad;
    hold <= 1'b0;
    txPayload <= sd;
    txPayloadValid <= 1'b1;
    while (nt < 53 || nr < 48) begin
      @(posedge mclk);
      if (txOut.valid && txOutReady) begin
        `CHK(({txOut.first, txOut.last, txOut.data}), ({nt == 0, nt == 52, nt < 5 ? e[39 - 8 * nt -: 8] : sd + 8'(nt - 5)}))
        if (nt == 52)
          hold <= 1'b1;
        nt++;
      end
      if (txPayloadReady && txPayloadValid)
        txPayload <= txPayload + 8'h01;
      if (sl)
        txPayloadValid <= ~txPayloadValid;
      if (rxHdrValid) begin
        `CHK(({rxHdr, rxHdrError}), ({1'b0, e[39:28], e[39:36], e[27:8], bad}))
        txHdr <= nh;
        cosetOn <= ncs;
        hv++;
      end
      if (rxPayload.valid) begin
        `CHK(({rxPayload.first, rxPayload.last, rxPayload.data}), ({nr == 0, nr == 47, sd + 8'(nr)}))
        nr++;
      end
    end
    `CHK(hv, 1)
    `CHK(rxInReady, 1'b1)
    $display("test %s done", name);
  endtask

  task automatic test_uni();
    run_cell("uni", H1, 1'b0, 1'b0, 1'b0, 8'h10, H2, 1'b1);
  endtask

  task automatic test_nni_coset_stall();
    run_cell("nni_coset_stall", H2, 1'b1, 1'b0, 1'b1, 8'hC0, H3, 1'b1);
  endtask

  task automatic test_bad_check_byte();
    run_cell("bad_check_byte", H3, 1'b1, 1'b1, 1'b0, 8'hF0, H1, 1'b0);
  endtask

  initial begin
    txHdr = H1;
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    test_uni();
    test_nni_coset_stall();
    test_bad_check_byte();
    test_uni();
    print_verdict();
  end
endmodule // tb
`default_nettype wire

// ### verilog/acf_cell_formatter.sv
// Cell header formatter: builds five-byte headers plus 48-byte payload, and parses incoming cells
// How it works
// - Every cell is 53 bytes, five header bytes then 48 payload bytes.
// - User-network format puts flow-control value in upper nibble of byte one.
// - Network-network format puts extra path bits in upper nibble of byte one.
// - Next 24 bits hold path identifier then 16-bit channel identifier.
// - Three bits after channel identifier carry the payload type code.
// - Lowest bit of byte four is the loss-priority flag, 1 means discardable.
// - Byte five is a check code over header bytes one to four.
// - Check code judges the header only, never the payload.
// - Payload follows check byte at once, supplied by adaptation source.
// - Check byte is CRC-8 x8+x2+x+1, plus x6+x4+x2+1 when coset on.
// - User format fields: 4 flow, 8 path, 16 channel, 3 type, 1 priority.
// - Network format path identifier is 12 bits: byte one and high nibble of byte two.
`timescale 1ns/10ps
`default_nettype none
module acf_cell_formatter
  import acf_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       reset,
  input  wire logic       cosetOn,
  input  wire acf_hdr_t   txHdr,
  input  wire logic [7:0] txPayload,
  input  wire logic       txPayloadValid,
  output logic            txPayloadReady,
  output acf_beat_t       txOut,
  input  wire logic       txOutReady,
  input  wire acf_beat_t  rxIn,
  output logic            rxInReady,
  output acf_hdr_t        rxHdr,
  output logic            rxHdrValid,
  output logic            rxHdrError,
  output acf_beat_t       rxPayload
);

  function automatic logic [7:0] crcByte(input logic [7:0] crc, input logic [7:0] din);
    logic [7:0] c;
    c = crc ^ din;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ((c << 1) ^ HEC_POLY) : (c << 1);
    end
    return c;
  endfunction

  function automatic logic [31:0] packHdr(input acf_hdr_t h);
    logic [31:0] w;
    w = '0;
    w[GFC_LSB +: 4]  = h.nni ? h.vpi[11:8] : h.gfc;
    w[VPI_LSB +: 8]  = h.vpi[7:0];
    w[VCI_LSB +: 16] = h.vci;
    w[PT_LSB +: 3]   = h.ptype;
    w[LOSS_LSB]      = h.lossPri;
    return w;
  endfunction

  function automatic logic [7:0] hecOf(input logic [31:0] w, input logic coset);
    logic [7:0] c;
    c = HEC_INIT;
    for (int b = 3; b >= 0; b--) begin
      c = crcByte(c, w[b*8 +: 8]);
    end
    return coset ? (c ^ HEC_COSET) : c;
  endfunction

  localparam logic [5:0] LAST_IDX = 6'(CELL_BYTES - 1);
  localparam logic [5:0] HEC_IDX  = 6'(HDR_CHECK_IDX);

  // Transmit side
  logic [5:0]  txIdx_reg, txIdx_next;
  logic [31:0] txWord_reg, txWord_next;
  logic        txCoset_reg, txCoset_next;
  acf_beat_t   txOut_reg, txOut_next;
  logic        txPayloadReady_reg;
  logic        txSlot;
  logic [7:0]  txByte;
  logic        txHave;

  // Header is latched at cell start so a mid-cell change cannot tear the header
  always_comb begin
    txWord_next  = txWord_reg;
    txCoset_next = txCoset_reg;
    txIdx_next   = txIdx_reg;
    txOut_next   = txOut_reg;
    txSlot       = !txOut_reg.valid || txOutReady;
    txHave       = 1'b0;
    txByte       = 8'h00;
    if (txIdx_reg == IDX_RESET) begin
      txWord_next  = packHdr(txHdr);
      txCoset_next = cosetOn;
    end
    if (txIdx_reg < HEC_IDX) begin
      txByte = (txIdx_reg == IDX_RESET) ? txWord_next[31:24] : txWord_reg[(3 - txIdx_reg) * 8 +: 8];
      txHave = 1'b1;
    end else if (txIdx_reg == HEC_IDX) begin
      txByte = hecOf(txWord_reg, txCoset_reg);
      txHave = 1'b1;
    end else begin
      txByte = txPayload;
      txHave = txPayloadValid;
    end
    if (txSlot) begin
      txOut_next.valid = txHave;
      txOut_next.data  = txByte;
      txOut_next.first = txIdx_reg == IDX_RESET;
      txOut_next.last  = txIdx_reg == LAST_IDX;
      if (txHave) begin
        txIdx_next = (txIdx_reg == LAST_IDX) ? IDX_RESET : txIdx_reg + 6'h01;
      end
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      txIdx_reg          <= IDX_RESET;
      txWord_reg         <= 32'h0000_0000;
      txCoset_reg        <= 1'b0;
      txOut_reg          <= '0;
      txPayloadReady_reg <= 1'b0;
    end else begin
      txIdx_reg          <= txIdx_next;
      txWord_reg         <= txWord_next;
      txCoset_reg        <= txCoset_next;
      txOut_reg          <= txOut_next;
      txPayloadReady_reg <= 1'b1;
    end
  end

  // Payload ready is combinational by nature; registered gate plus slot keeps handshake exact
  assign txPayloadReady = txPayloadReady_reg && txSlot && (txIdx_reg > HEC_IDX);
  assign txOut          = txOut_reg;

  // Header bytes as they left the pins, so the check byte is judged against what was really sent
  logic [31:0] txSeen_reg, txSeen_next;

  always_comb begin
    txSeen_next = txSeen_reg;
    if (txOut_reg.valid && txOutReady && txIdx_reg != IDX_RESET && txIdx_reg <= HEC_IDX) begin
      txSeen_next = {txSeen_reg[23:0], txOut_reg.data};
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      txSeen_reg <= 32'h0000_0000;
    end else begin
      txSeen_reg <= txSeen_next;
    end
  end

  // Receive side
  logic [5:0]  rxIdx_reg, rxIdx_next;
  logic [31:0] rxWord_reg, rxWord_next;
  acf_hdr_t    rxHdr_reg, rxHdr_next;
  logic        rxHdrValid_reg, rxHdrValid_next;
  logic        rxHdrError_reg, rxHdrError_next;
  acf_beat_t   rxPay_reg, rxPay_next;
  logic        rxInReady_reg;

  // Header check only flags the header; payload passes untouched either way
  always_comb begin
    rxIdx_next      = rxIdx_reg;
    rxWord_next     = rxWord_reg;
    rxHdr_next      = rxHdr_reg;
    rxHdrValid_next = 1'b0;
    rxHdrError_next = rxHdrError_reg;
    rxPay_next      = '0;
    if (rxIn.valid) begin
      rxIdx_next = (rxIdx_reg == LAST_IDX) ? IDX_RESET : rxIdx_reg + 6'h01;
      if (rxIdx_reg < HEC_IDX) begin
        rxWord_next = {rxWord_reg[23:0], rxIn.data};
      end else if (rxIdx_reg == HEC_IDX) begin
        rxHdr_next.nni     = 1'b0; // Format is not on the line; the sink reads gfc or vpi as it needs
        rxHdr_next.gfc     = rxWord_reg[GFC_LSB +: 4];
        rxHdr_next.vpi     = {rxWord_reg[GFC_LSB +: 4], rxWord_reg[VPI_LSB +: 8]};
        rxHdr_next.vci     = rxWord_reg[VCI_LSB +: 16];
        rxHdr_next.ptype   = rxWord_reg[PT_LSB +: 3];
        rxHdr_next.lossPri = rxWord_reg[LOSS_LSB];
        rxHdrError_next    = rxIn.data != hecOf(rxWord_reg, cosetOn);
        rxHdrValid_next    = 1'b1;
      end else begin
        rxPay_next.valid = 1'b1;
        rxPay_next.data  = rxIn.data;
        rxPay_next.first = rxIdx_reg == HEC_IDX + 6'h01;
        rxPay_next.last  = rxIdx_reg == LAST_IDX;
      end
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rxIdx_reg      <= IDX_RESET;
      rxWord_reg     <= 32'h0000_0000;
      rxHdr_reg      <= '0;
      rxHdrValid_reg <= 1'b0;
      rxHdrError_reg <= 1'b0;
      rxPay_reg      <= '0;
      rxInReady_reg  <= 1'b0;
    end else begin
      rxIdx_reg      <= rxIdx_next;
      rxWord_reg     <= rxWord_next;
      rxHdr_reg      <= rxHdr_next;
      rxHdrValid_reg <= rxHdrValid_next;
      rxHdrError_reg <= rxHdrError_next;
      rxPay_reg      <= rxPay_next;
      rxInReady_reg  <= 1'b1;
    end
  end

  // Receive never stalls: the sink must take one byte a cycle
  assign rxInReady  = rxInReady_reg;
  assign rxHdr      = rxHdr_reg;
  assign rxHdrValid = rxHdrValid_reg;
  assign rxHdrError = rxHdrError_reg;
  assign rxPayload  = rxPay_reg;

  a_tx_cell_len: assert property (@(posedge mclk) disable iff (reset)
    (txOut.valid && txOutReady && txOut.last) |-> txIdx_reg == IDX_RESET)
    else $error("cell length wrong");
  a_tx_first_hdr: assert property (@(posedge mclk) disable iff (reset)
    (txOut.valid && txOut.first) |-> txIdx_reg == 6'h01)
    else $error("cell start misplaced");
  a_tx_hec_byte: assert property (@(posedge mclk) disable iff (reset)
    (txOut.valid && txIdx_reg == HEC_IDX + 6'h01) |-> txOut.data == hecOf(txSeen_reg, txCoset_reg))
    else $error("check byte wrong");
  a_tx_hold: assert property (@(posedge mclk) disable iff (reset)
    (txOut.valid && !txOutReady) |=> $stable(txOut))
    else $error("output changed under stall");
  a_rx_hdr_pulse: assert property (@(posedge mclk) disable iff (reset)
    rxHdrValid |=> !rxHdrValid)
    else $error("header valid not a pulse");
  a_rx_payload_after: assert property (@(posedge mclk) disable iff (reset)
    (rxHdrValid && rxIn.valid) |=> rxPayload.first)
    else $error("payload not right after check");
  a_rx_err_stable: assert property (@(posedge mclk) disable iff (reset)
    rxPayload.valid |-> $stable(rxHdrError))
    else $error("payload touched header error");
  a_rx_vci: assert property (@(posedge mclk) disable iff (reset)
    rxHdrValid |-> rxHdr.vci == $past(rxWord_reg[VCI_LSB +: 16]))
    else $error("channel field wrong");

endmodule : acf_cell_formatter
`default_nettype wire

// ### verilog/acf_pkg.sv
// Package for the cell header formatter: cell geometry, header layout, check code constants
package acf_pkg;
  localparam int unsigned CELL_BYTES    = 53;
  localparam int unsigned HDR_BYTES     = 5;
  localparam int unsigned PAYLOAD_BYTES = 48;
  localparam int unsigned HDR_CHECK_IDX = 4;
  localparam logic [7:0]  HEC_POLY      = 8'h07;
  localparam logic [7:0]  HEC_COSET     = 8'h55;
  localparam logic [7:0]  HEC_INIT      = 8'h00;
  localparam int unsigned GFC_LSB       = 28;
  localparam int unsigned VPI_LSB       = 20;
  localparam int unsigned VCI_LSB       = 4;
  localparam int unsigned PT_LSB        = 1;
  localparam int unsigned LOSS_LSB      = 0;
  localparam logic [5:0]  IDX_RESET     = 6'h00;

  typedef struct packed {
    logic        nni;
    logic [11:0] vpi;
    logic [3:0]  gfc;
    logic [15:0] vci;
    logic [2:0]  ptype;
    logic        lossPri;
  } acf_hdr_t;

  typedef struct packed {
    logic       valid;
    logic       first;
    logic       last;
    logic [7:0] data;
  } acf_beat_t;
endpackage : acf_pkg
